// >>> dtc_pkg.sv
// Package with constants and carrier types for the dual timer block
package dtc_pkg;
  localparam logic [1:0] DTC_MODE_13BIT = 2'h0;
  localparam logic [1:0] DTC_MODE_16BIT = 2'h1;
  localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
  localparam logic [1:0] DTC_MODE_SPLIT = 2'h3;
  localparam logic [1:0] DTC_PRE_DIV4 = 2'h1;
  localparam logic [1:0] DTC_PRE_DIV48 = 2'h2;
  localparam logic [1:0] DTC_PRE_EXT8 = 2'h3;
  localparam int DTC_DIV4 = 4;
  localparam int DTC_DIV48 = 48;
  localparam int DTC_EXT_DIV8 = 8;
  localparam logic [7:0] DTC_MASK13_LOW = 8'h1F;
  localparam logic [7:0] DTC_BYTE_ONES = 8'hFF;
  localparam logic [7:0] DTC_BYTE_ZERO = 8'h00;

  // Per-timer control bits, as software holds them
  typedef struct packed {
    logic run;
    logic gate_select;
    logic source_select;
    logic [1:0] mode;
  } dtc_ctrl_t;

  // Software write to one count byte
  typedef struct packed {
    logic low_we;
    logic high_we;
    logic [7:0] data;
  } dtc_wr_t;
endpackage

// >>> dtc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dtc_sync
  import dtc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic din,
  output logic dout,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;
  logic agreed;
  wire change = (s2 == s3) && (s3 != agreed);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      agreed <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (change) begin
        agreed <= s3;
      end
    end
  end

  assign dout = agreed;
  assign rise = change && s3;
endmodule
`default_nettype wire

// >>> dtc_timers.sv
// Two counter/timers with 13-bit, 16-bit, auto-reload and split modes
//
// Functional notes
// - Mode 1 counts the full 16 bits of the high and low bytes.
// - Mode 2 counts in the low byte and keeps the reload value in high.
// - Mode 2 low byte wrap from FF sets the overflow flag and reloads low.
// - A set overflow flag with its interrupt enabled raises the request.
// - Mode 2 never alters the reload byte; only software writes change it.
// - Timer 1 in mode 2 uses its own bits and behaves like timer 0, except while timer 0 is split.
// - Except timer 1 in mode 3 or while timer 0 is split, a timer counts when run is set and gate is 0 or the irq pin is active.
// - Mode 3 splits timer 0; its low byte uses timer 0 bits and sources.
// - In mode 3 the timer 0 high byte counts only internal clocks.
// - In mode 3 the timer 0 high byte runs on timer 1 run, sets its flag.
// - With timer 0 in mode 3, timer 1 takes no external clock and no flag.
// - With timer 0 in mode 3, timer 1 overflows still give baud ticks.
// - With timer 0 in mode 3, timer 1 runs in modes 0-2, stops in mode 3.
`timescale 1ns/1ps
`default_nettype none
module dtc_timers
  import dtc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire dtc_ctrl_t timer0_ctrl,
  input wire dtc_ctrl_t timer1_ctrl,
  input wire logic [1:0] timer_prescale_select,
  input wire logic timer1_clock_select,
  input wire logic timer0_irq_enable,
  input wire logic timer1_irq_enable,
  input wire logic ext_irq0_polarity,
  input wire logic ext_irq1_polarity,
  input wire logic ext_irq0_input,
  input wire logic ext_irq1_input,
  input wire logic timer0_count_input,
  input wire logic timer1_count_input,
  input wire logic external_clock,
  input wire dtc_wr_t timer0_write,
  input wire dtc_wr_t timer1_write,
  input wire logic timer0_flag_clear,
  input wire logic timer1_flag_clear,
  output logic [7:0] timer0_low_count,
  output logic [7:0] timer0_high_count,
  output logic [7:0] timer1_low_count,
  output logic [7:0] timer1_high_count,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic timer0_irq_request,
  output logic timer1_irq_request,
  output logic timer1_overflow_tick
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic irq0_level;
  logic irq1_level;
  logic cnt0_rise;
  logic cnt1_rise;
  logic external_clock_rise;

  // Three flops cost latency, but a pin glitch cannot count twice
  dtc_sync u_sync_irq0 (
    .clock(clock),
    .nrst(nrst),
    .din(ext_irq0_input),
    .dout(irq0_level),
    .rise()
  );
  dtc_sync u_sync_irq1 (
    .clock(clock),
    .nrst(nrst),
    .din(ext_irq1_input),
    .dout(irq1_level),
    .rise()
  );
  dtc_sync u_sync_cnt0 (
    .clock(clock),
    .nrst(nrst),
    .din(timer0_count_input),
    .dout(),
    .rise(cnt0_rise)
  );
  dtc_sync u_sync_cnt1 (
    .clock(clock),
    .nrst(nrst),
    .din(timer1_count_input),
    .dout(),
    .rise(cnt1_rise)
  );
  // External clock only paces a divider, so it is sampled like a pin
  dtc_sync u_sync_external_clock (
    .clock(clock),
    .nrst(nrst),
    .din(external_clock),
    .dout(),
    .rise(external_clock_rise)
  );

  // ****************************************
  // Prescaler
  // ****************************************
  logic [5:0] pre_div;
  logic [2:0] ext_div;
  logic pre_tick;
  wire sel_ext8 = (timer_prescale_select == DTC_PRE_EXT8);
  wire sel_div48 = (timer_prescale_select == DTC_PRE_DIV48);
  wire sel_div4 = (timer_prescale_select == DTC_PRE_DIV4);
  wire [5:0] pre_limit = sel_div48 ? 6'(DTC_DIV48 - 1) : 6'(DTC_DIV4 - 1);
  wire pre_wrap = (pre_div >= pre_limit);
  wire ext_wrap = (ext_div == 3'(DTC_EXT_DIV8 - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pre_div <= 6'h00;
      ext_div <= 3'h0;
    end else begin
      pre_div <= pre_wrap ? 6'h00 : pre_div + 6'h01;
      if (external_clock_rise) begin
        ext_div <= ext_div + 3'h1;
      end
    end
  end

  // Code 00 has no defined source; it is treated as divide by 4
  always_comb begin
    if (sel_ext8) begin
      pre_tick = external_clock_rise && ext_wrap;
    end else begin
      pre_tick = pre_wrap && (sel_div4 || sel_div48 ||
                              timer_prescale_select == 2'h0);
    end
  end

  // ****************************************
  // Count enables
  // ****************************************
  wire split_mode = (timer0_ctrl.mode == DTC_MODE_SPLIT);
  wire irq0_active = (irq0_level == ext_irq0_polarity);
  wire irq1_active = (irq1_level == ext_irq1_polarity);
  wire timer0_gate_select_ok = !timer0_ctrl.gate_select || irq0_active;
  wire gate1_ok = !timer1_ctrl.gate_select || irq1_active;
  // Timer 0 source is the count pin or the prescaled clock, timer 1 may bypass
  wire t0_src = timer0_ctrl.source_select ? cnt0_rise : pre_tick;
  wire t1_int = timer1_clock_select ? 1'b1 : pre_tick;
  // External count input is refused while timer 0 is split
  wire t1_src = (timer1_ctrl.source_select && !split_mode) ?
                cnt1_rise : t1_int;
  wire t0_inc = timer0_ctrl.run && timer0_gate_select_ok && t0_src;
  // Split high byte: timer 1 run, internal clock only
  wire th0_inc = split_mode && timer1_ctrl.run && pre_tick;
  // While split, timer 1 ignores its run bit; its mode and its gate start it
  wire t1_mode_ok = (timer1_ctrl.mode != DTC_MODE_SPLIT);
  wire t1_run = split_mode ? t1_mode_ok : timer1_ctrl.run;
  wire t1_inc = t1_run && t1_mode_ok && gate1_ok && t1_src;

  // ****************************************
  // Counter next values
  // ****************************************
  logic [7:0] next_t0_low;
  logic [7:0] next_t0_high;
  logic [7:0] next_t1_low;
  logic [7:0] next_t1_high;
  logic t0_ovf;
  logic t1_ovf;
  logic th0_ovf;

  function automatic logic [16:0] dtc_step(
    input logic [1:0] mode,
    input logic [7:0] low,
    input logic [7:0] high
  );
    logic [16:0] r;
    logic [13:0] c13;
    logic [16:0] c16;
    r = {1'b0, high, low};
    c13 = {1'b0, high, low[4:0]} + 14'h0001;
    c16 = {1'b0, high, low} + 17'h00001;
    case (mode)
      DTC_MODE_13BIT: begin
        r = {c13[13], c13[12:5], low[7:5], c13[4:0]};
      end
      DTC_MODE_16BIT: begin
        r = c16;
      end
      DTC_MODE_RELOAD: begin
        // High byte is the reload value and is never written here
        if (low == DTC_BYTE_ONES) begin
          r = {1'b1, high, high};
        end else begin
          r = {1'b0, high, low + 8'h01};
        end
      end
      default: begin
        r = {low == DTC_BYTE_ONES, high, low + 8'h01};
      end
    endcase
    return r;
  endfunction

  wire [16:0] t0_step = dtc_step(timer0_ctrl.mode, timer0_low_count,
                                 timer0_high_count);
  wire [16:0] t1_step = dtc_step(timer1_ctrl.mode, timer1_low_count,
                                 timer1_high_count);

  // Step results, named so the selection below reads plainly
  wire [7:0] t0_step_low = t0_step[7:0];
  wire [7:0] t0_step_high = t0_step[15:8];
  wire t0_step_ovf = t0_step[16];
  wire [7:0] t1_step_low = t1_step[7:0];
  wire [7:0] t1_step_high = t1_step[15:8];
  wire t1_step_ovf = t1_step[16];
  // Split high byte is a plain 8-bit counter
  wire [7:0] th0_step = timer0_high_count + 8'h01;
  wire th0_step_ovf = (timer0_high_count == DTC_BYTE_ONES);

  always_comb begin
    next_t0_low = timer0_low_count;
    next_t0_high = timer0_high_count;
    next_t1_low = timer1_low_count;
    next_t1_high = timer1_high_count;
    t0_ovf = 1'b0;
    t1_ovf = 1'b0;
    th0_ovf = 1'b0;
    if (t0_inc) begin
      next_t0_low = t0_step_low;
      if (!split_mode) begin
        next_t0_high = t0_step_high;
      end
      t0_ovf = t0_step_ovf;
    end
    if (th0_inc) begin
      next_t0_high = th0_step;
      th0_ovf = th0_step_ovf;
    end
    if (t1_inc) begin
      next_t1_low = t1_step_low;
      next_t1_high = t1_step_high;
      t1_ovf = t1_step_ovf;
    end
    // Software writes take priority over counting
    if (timer0_write.low_we) begin
      next_t0_low = timer0_write.data;
    end
    if (timer0_write.high_we) begin
      next_t0_high = timer0_write.data;
    end
    if (timer1_write.low_we) begin
      next_t1_low = timer1_write.data;
    end
    if (timer1_write.high_we) begin
      next_t1_high = timer1_write.data;
    end
  end

  // Timer 1 flag source depends on the split
  wire set_tf1 = split_mode ? th0_ovf : t1_ovf;

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer0_low_count <= DTC_BYTE_ZERO;
      timer0_high_count <= DTC_BYTE_ZERO;
      timer1_low_count <= DTC_BYTE_ZERO;
      timer1_high_count <= DTC_BYTE_ZERO;
    end else begin
      timer0_low_count <= next_t0_low;
      timer0_high_count <= next_t0_high;
      timer1_low_count <= next_t1_low;
      timer1_high_count <= next_t1_high;
    end
  end

  // ****************************************
  // Overflow flags and baud tick
  // ****************************************
  // Set wins over a clear in the same cycle, so no overflow is lost
  wire next_tf0 = t0_ovf ||
                  (timer0_overflow_flag && !timer0_flag_clear);
  wire next_tf1 = set_tf1 ||
                  (timer1_overflow_flag && !timer1_flag_clear);
  // The tick bypasses the flag path, so baud timing survives the split
  wire next_tick = t1_ovf;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
      timer1_overflow_tick <= 1'b0;
    end else begin
      timer0_overflow_flag <= next_tf0;
      timer1_overflow_flag <= next_tf1;
      timer1_overflow_tick <= next_tick;
    end
  end

  assign timer0_irq_request = timer0_overflow_flag && timer0_irq_enable;
  assign timer1_irq_request = timer1_overflow_flag && timer1_irq_enable;
endmodule
`default_nettype wire

// >>> dtc_timers_assertions.sv
// Port-level checks for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtc_timers_chk
  import dtc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire dtc_ctrl_t timer0_ctrl,
  input wire dtc_ctrl_t timer1_ctrl,
  input wire logic timer0_irq_enable,
  input wire logic timer1_irq_enable,
  input wire dtc_wr_t timer0_write,
  input wire dtc_wr_t timer1_write,
  input wire logic timer0_flag_clear,
  input wire logic [7:0] timer0_low_count,
  input wire logic [7:0] timer0_high_count,
  input wire logic [7:0] timer1_low_count,
  input wire logic [7:0] timer1_high_count,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer0_irq_request,
  input wire logic timer1_irq_request,
  input wire logic timer1_overflow_tick
);
  // ************
  // Properties
  // ************
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire t0_nowr = !timer0_write.low_we && !timer0_write.high_we;
  wire t1_nowr = !timer1_write.low_we && !timer1_write.high_we;
  wire t0_rl = timer0_ctrl.mode == DTC_MODE_RELOAD;
  wire t1_rl = timer1_ctrl.mode == DTC_MODE_RELOAD;
  a_irq0_follows: assert property (
    timer0_irq_request == (timer0_overflow_flag && timer0_irq_enable))
    else $error("irq0 not flag and enable");
  a_irq1_follows: assert property (
    timer1_irq_request == (timer1_overflow_flag && timer1_irq_enable))
    else $error("irq1 not flag and enable");
  a_reload_kept: assert property (
    t0_rl && !timer0_write.high_we |=> $stable(timer0_high_count))
    else $error("reload byte changed");
  a_idle_holds: assert property (
    !timer0_ctrl.run && !timer0_write.low_we |=> $stable(timer0_low_count))
    else $error("low byte moved while stopped");
  a_wrap_reload: assert property (
    (t0_rl && timer0_low_count == DTC_BYTE_ONES && t0_nowr)
    ##1 $changed(timer0_low_count) |-> timer0_overflow_flag
    && timer0_low_count == $past(timer0_high_count))
    else $error("wrap without reload or flag");
  a_mode0_top: assert property (
    timer0_ctrl.mode == DTC_MODE_13BIT && !timer0_write.low_we
    |=> timer0_low_count[7:5] == $past(timer0_low_count[7:5]))
    else $error("upper low bits moved in 13-bit mode");
  a_t1_mode3_off: assert property (
    timer1_ctrl.mode == DTC_MODE_SPLIT && t1_nowr
    |=> $stable({timer1_high_count, timer1_low_count}))
    else $error("timer 1 counted in mode 3");
  a_split_flag: assert property (
    $rose(timer1_overflow_flag) && timer0_ctrl.mode == DTC_MODE_SPLIT
    && $past(timer0_ctrl.mode) == DTC_MODE_SPLIT
    |-> $past(timer0_high_count) == DTC_BYTE_ONES)
    else $error("timer 1 flag not from high byte wrap");
  a_tick_on_wrap: assert property (
    (t1_rl && timer1_low_count == DTC_BYTE_ONES && t1_nowr)
    ##1 $changed(timer1_low_count) |-> ##[0:1] timer1_overflow_tick)
    else $error("no tick on timer 1 wrap");
  a_flag_sticky: assert property (
    $fell(timer0_overflow_flag) |-> $past(timer0_flag_clear))
    else $error("flag dropped without clear");
  c_reload: cover property (t0_rl && timer0_overflow_flag);
  c_split: cover property ($rose(timer1_overflow_flag));
  c_tick: cover property (timer1_overflow_tick);
endmodule
bind dtc_timers dtc_timers_chk #(.CNT_W(CNT_W)) dtc_timers_chk_i (.*);
`default_nettype wire

// >>> dtc_pins.sv
// Model of the gate, count and external clock pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pins
(
  input wire logic clock,
  input wire logic timer0_gate_select_level,
  input wire logic gate1_level,
  input wire logic pulse_on,
  input wire logic external_clock_on,
  output logic ext_irq0_input,
  output logic ext_irq1_input,
  output logic timer0_count_input,
  output logic timer1_count_input,
  output logic external_clock
);
  // Pins move on the falling edge, unrelated to the sampling edge
  logic [2:0] phase = 3'h0;
  always @(negedge clock) phase <= phase + 3'h1;
  assign ext_irq0_input = timer0_gate_select_level;
  assign ext_irq1_input = gate1_level;
  assign timer0_count_input = pulse_on & phase[2];
  assign timer1_count_input = pulse_on & phase[2];
  // Period of eight system clocks, slow enough for the synchroniser
  assign external_clock = external_clock_on & phase[2];
endmodule
`default_nettype wire

// >>> dtc_timers_tb.sv
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtc_timers_tb
  import dtc_pkg::*;
;
  logic clock = 0, nrst = 0;
  dtc_ctrl_t timer0_ctrl = '0, timer1_ctrl = '0;
  logic [1:0] timer_prescale_select = 2'h1;
  logic timer1_clock_select = 0, timer0_irq_enable = 1;
  logic timer1_irq_enable = 1, ext_irq0_polarity = 1, ext_irq1_polarity = 1;
  dtc_wr_t timer0_write = '0, timer1_write = '0;
  logic timer0_flag_clear = 0, timer1_flag_clear = 0;
  logic [7:0] timer0_low_count, timer0_high_count;
  logic [7:0] timer1_low_count, timer1_high_count;
  logic timer0_overflow_flag, timer1_overflow_flag, timer1_overflow_tick;
  logic timer0_irq_request, timer1_irq_request;
  logic ext_irq0_input, ext_irq1_input, external_clock;
  logic timer0_count_input, timer1_count_input;
  logic timer0_gate_select_level = 0, gate1_level = 0, pulse_on = 0, external_clock_on = 1;
  int n_errors = 0, checked = 0, cycles = 0, n;
  int dv[4] = '{0, 4, 48, 64};
  dtc_timers dtc_timers_i (.*);
  dtc_pins dtc_pins_i (.*);
  always #5 clock = ~clock;
  // ************
  // Tasks
  // ************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(input bit t, input bit lo, input logic [7:0] d);
    @(posedge clock);
    if (t) timer1_write <= '{lo, !lo, d};
    else timer0_write <= '{lo, !lo, d};
    @(posedge clock);
    timer0_write <= '0;
    timer1_write <= '0;
  endtask
  task automatic clr(input bit t);
    @(posedge clock);
    if (t) timer1_flag_clear <= 1'b1;
    else timer0_flag_clear <= 1'b1;
    @(posedge clock);
    timer0_flag_clear <= 1'b0;
    timer1_flag_clear <= 1'b0;
  endtask
  task automatic wait_hi(input bit t);
    for (int i = 0; i < 400; i++) begin
      if ((t ? timer1_overflow_flag : timer0_overflow_flag) === 1'b1) break;
      step(1);
    end
  endtask
  // Cycles up to the next tick; the first call only finds the phase
  task automatic gap(output int g);
    g = 0;
    do begin
      step(1);
      g++;
    end while (timer1_overflow_tick !== 1'b1 && g < 200);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  // ************
  // Sequence
  // ************
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    timer1_ctrl <= '{1'b1, 1'b0, 1'b0, DTC_MODE_RELOAD};
    timer1_clock_select <= 1'b1;
    wr(1, 0, 8'h55);
    wr(1, 1, 8'hFE);
    step(2);
    chk(timer1_low_count, 8'h55);
    chk(timer1_overflow_flag, 1'b1);
    @(posedge clock);
    timer1_clock_select <= 1'b0;
    wr(1, 0, 8'hFF);
    wr(1, 1, 8'hFF);
    for (int p = 1; p < 4; p++) begin
      @(posedge clock);
      timer_prescale_select <= p[1:0];
      gap(n);
      gap(n);
      gap(n);
      chk(n[15:0], dv[p][15:0]);
    end
    @(posedge clock);
    timer_prescale_select <= DTC_PRE_DIV4;
    timer1_ctrl <= '{1'b0, 1'b0, 1'b0, DTC_MODE_SPLIT};
    wr(0, 0, 8'hA0);
    wr(0, 1, 8'hFF);
    @(posedge clock);
    timer0_ctrl <= '{1'b1, 1'b0, 1'b0, DTC_MODE_RELOAD};
    wait_hi(0);
    chk({timer0_high_count, timer0_low_count}, 16'hA0A0);
    chk(timer0_irq_request, 1'b1);
    @(posedge clock);
    timer0_irq_enable <= 1'b0;
    timer0_ctrl.run <= 1'b0;
    step(1);
    chk(timer0_irq_request, 1'b0);
    clr(0);
    step(1);
    chk(timer0_overflow_flag, 1'b0);
    @(posedge clock);
    timer0_ctrl <= '{1'b1, 1'b1, 1'b0, DTC_MODE_13BIT};
    timer0_irq_enable <= 1'b1;
    wr(0, 0, 8'h00);
    wr(0, 1, 8'hFF);
    step(40);
    chk(timer0_low_count, 8'hFF);
    @(posedge clock);
    timer0_gate_select_level <= 1'b1;
    for (int i = 0; i < 60 && timer0_high_count !== 8'h01; i++) step(1);
    chk(timer0_low_count, 8'hE0);
    clr(1);
    @(posedge clock);
    timer0_ctrl <= '{1'b0, 1'b0, 1'b0, DTC_MODE_SPLIT};
    timer1_ctrl <= '{1'b1, 1'b0, 1'b0, DTC_MODE_SPLIT};
    wr(0, 0, 8'hFE);
    wait_hi(1);
    chk(timer0_high_count, 8'h00);
    chk(timer1_irq_request, 1'b1);
    chk(timer1_low_count, 8'hFF);
    clr(1);
    @(posedge clock);
    timer1_ctrl.mode <= DTC_MODE_RELOAD;
    timer1_clock_select <= 1'b1;
    gap(n);
    gap(n);
    chk(n[15:0], 16'h0001);
    chk(timer1_overflow_flag, 1'b0);
    @(posedge clock);
    timer0_ctrl <= '{1'b1, 1'b0, 1'b1, DTC_MODE_SPLIT};
    timer1_ctrl.source_select <= 1'b1;
    wr(0, 1, 8'hFE);
    @(posedge clock);
    pulse_on <= 1'b1;
    wait_hi(0);
    chk(timer0_low_count, 8'h00);
    gap(n);
    gap(n);
    chk(n[15:0], 16'h0001);
    @(posedge clock);
    timer0_ctrl <= '{1'b0, 1'b0, 1'b0, DTC_MODE_16BIT};
    clr(0);
    wr(0, 0, 8'hFF);
    wr(0, 1, 8'hFE);
    @(posedge clock);
    timer0_ctrl.run <= 1'b1;
    wait_hi(0);
    chk({timer0_high_count, timer0_low_count}, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
